// File: sim/lsu_model.sv
/*
 * load/store unit model feeding the aperture decoder's access port.
 * assumes one clock and synchronous active-high reset shared with the decoder.
 */
module lsu_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic req,
	input wire logic [31:0] req_addr,
	input wire logic req_load,
	output logic acc_valid,
	output logic [31:0] acc_addr,
	output logic acc_load
);
	timeunit 1ns;
	timeprecision 1ps;
	// bench keeps windows aligned and apart, setting them after boot and rewriting them mid-run
	always_ff @(posedge sys_clk) begin
		acc_valid <= rst ? 1'b0 : req;
		// idle address is scrambled so a stale value never looks valid
		acc_addr <= req ? req_addr : ~acc_addr;
		acc_load <= req ? req_load : ~acc_load;
	end
endmodule : lsu_model

// File: sim/test_address_aperture_decoder.sv
/*
 * self-checking bench for the aperture decoder: apb setup, access decode.
 * assumes lsu_model and the decoder with its package and header.
 */
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module test_address_aperture_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	import aperture_pkg::*;
	typedef struct packed {logic [31:0] a; logic ld; target_t t;} row_t;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, req = 0, req_load = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, req_addr = 0, prdata, hole_rdata, acc_addr, rd;
	logic pready, pslverr, acc_valid, acc_load, sel_hole, sel_dram, sel_regwin, sel_pci;
	logic hole_done, er;
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	row_t rows[10] = '{'{32'h0, 1'b1, TGT_HOLE}, '{32'hff, 1'b1, TGT_HOLE},
		'{32'h100, 1'b1, TGT_PCI}, '{32'h10, 1'b0, TGT_PCI}, '{32'h1000_0000, 1'b1, TGT_DRAM},
		'{32'h10ff_fffc, 1'b0, TGT_DRAM}, '{32'h1100_0000, 1'b1, TGT_PCI},
		'{32'hefe0_0000, 1'b1, TGT_REGWIN}, '{32'hefff_fffc, 1'b0, TGT_REGWIN},
		'{32'hf000_0000, 1'b1, TGT_PCI}};
	always #10 sys_clk = ~sys_clk;
	lsu_model lsu_model_i (.sys_clk, .rst, .req, .req_addr, .req_load, .acc_valid, .acc_addr,
		.acc_load);
	address_aperture_decoder address_aperture_decoder_i (.sys_clk, .rst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .acc_valid, .acc_addr, .acc_load,
		.sel_hole, .sel_dram, .sel_regwin, .sel_pci, .hole_done, .hole_rdata);
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// request held until pready is seen high at a rising edge; data taken there
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task acc(input logic [31:0] a, input logic ld, input target_t t);
		@(posedge sys_clk);
		req <= 1;
		req_addr <= a;
		req_load <= ld;
		@(posedge sys_clk);
		#1 `CK({sel_pci, sel_regwin, sel_dram, sel_hole}, t)
	endtask : acc
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 0;
		apb(0, 12'h008, 0);
		`CK(rd, 32'hefe0_0000)
		acc(32'h10, 1, TGT_HOLE);
		$display("reset test done");
		apb(1, 12'h000, 32'h1000_0000);
		apb(1, 12'h004, 32'h1100_0000);
		foreach (rows[i]) acc(rows[i].a, rows[i].ld, rows[i].t);
		$display("row test done");
		acc(32'h20, 1, TGT_HOLE);
		@(posedge sys_clk);
		#1 `CK(hole_done, 1'b1)
		`CK(hole_rdata, 32'h0)
		apb(1, 12'h00c, 32'h1);
		acc(32'h20, 1, TGT_PCI);
		apb(1, 12'h00c, 32'h0);
		apb(1, 12'h004, 32'h2000_0000);
		acc(32'h13ff_fffc, 1, TGT_DRAM);
		acc(32'h1400_0000, 1, TGT_PCI);
		apb(1, 12'h000, 32'h0);
		apb(1, 12'h004, 32'h1000);
		acc(32'h20, 1, TGT_DRAM);
		apb(1, 12'h008, 32'h8000_0000);
		acc(32'h801f_fffc, 0, TGT_REGWIN);
		acc(32'h8020_0000, 1, TGT_PCI);
		apb(0, 12'h020, 0);
		`CK(er, 1'b1)
		apb(0, 12'h010, 0);
		`CK(rd[3:0], 4'h8)
		@(posedge sys_clk);
		req <= 0;
		repeat (2) @(posedge sys_clk);
		#1 `CK({sel_pci, sel_regwin, sel_dram, sel_hole}, 4'h0)
		$display("edge test done");
		apb(1, 12'h00c, 32'h1);
		@(posedge sys_clk);
		rst <= 1;
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		apb(0, 12'h00c, 0);
		`CK(rd, 32'h0)
		apb(0, 12'h008, 0);
		`CK(rd, 32'hefe0_0000)
		apb(0, 12'h010, 0);
		`CK(rd, 32'h0)
		acc(32'h40, 1, TGT_HOLE);
		$display("reset again test done");
		tally_and_finish;
	end
endmodule : test_address_aperture_decoder

// File: verilog/address_aperture_decoder.sv
/*
 * address aperture decoder: sorts each load/store address into hole, dram window,
 * register window or pci region, with its window registers behind an apb slave.
 * assumes one 50 mhz clock, synchronous active-high reset, and a load/store unit
 * that presents address and direction for as long as acc_valid is high.
 */
`include "aperture_defs.svh"

module address_aperture_decoder (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic acc_valid,
	input wire logic [31:0] acc_addr,
	input wire logic acc_load,
	output logic sel_hole,
	output logic sel_dram,
	output logic sel_regwin,
	output logic sel_pci,
	output logic hole_done,
	output logic [31:0] hole_rdata
);
	import aperture_pkg::*;

	function automatic regsel_t reg_decode(input logic [11:0] a);
		case (a)
			`OFS_DRAM_BASE: reg_decode = REG_DRAM_BASE;
			`OFS_DRAM_LIMIT: reg_decode = REG_DRAM_LIMIT;
			`OFS_REGWIN_BASE: reg_decode = REG_REGWIN_BASE;
			`OFS_LOCK_CTL: reg_decode = REG_LOCK_CTL;
			`OFS_STATUS: reg_decode = REG_STATUS;
			default: reg_decode = regsel_t'(5'h00);
		endcase
	endfunction : reg_decode

	logic [31:0] dram_base_q, dram_base_d;
	logic [31:0] dram_limit_q, dram_limit_d;
	logic [31:0] regwin_base_q, regwin_base_d;
	logic [31:0] lock_ctl_q, lock_ctl_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	target_t last_tgt_q, last_tgt_d;
	logic [15:0] hole_cnt_q, hole_cnt_d;
	logic hole_done_q, hole_done_d;

	logic [32:0] dram_cap;
	logic [31:0] dram_top;
	logic hit_dram, hit_regwin, hole_range, hole_active, hit_hole;
	logic setup, commit;
	regsel_t rsel;

	// window limit clamped so a bad limit cannot open more than 64 MB
	always_comb begin
		dram_cap = {1'b0, dram_base_q} + `DRAM_MAX_SIZE;
		if (dram_cap[32] || ({1'b0, dram_limit_q} < dram_cap)) begin
			dram_top = dram_limit_q;
		end else begin
			dram_top = dram_cap[31:0];
		end
		// limit taken as exclusive; base == limit means an empty window
		hit_dram = (acc_addr >= dram_base_q) && (acc_addr < dram_top);
		hit_regwin = (acc_addr[31:`REGWIN_LSB] == regwin_base_q[31:`REGWIN_LSB]);
		hole_range = (acc_addr <= `HOLE_TOP);
		// any dram window reaching into 0..0xff kills the hole outright
		hole_active = !lock_ctl_q[`HOLE_DIS_BIT]
			&& !((dram_base_q <= `HOLE_TOP) && (dram_top > dram_base_q));
		hit_hole = hole_active && hole_range && acc_load;
	end

	// dram wins over the register window; overlap is software's fault anyway
	always_comb begin
		sel_hole = acc_valid && hit_hole;
		sel_dram = acc_valid && !hit_hole && hit_dram;
		sel_regwin = acc_valid && !hit_hole && !hit_dram && hit_regwin;
		sel_pci = acc_valid && !hit_hole && !hit_dram && !hit_regwin;
	end

	assign setup = psel && !penable;
	assign commit = psel && penable && pready_q;
	assign rsel = reg_decode(paddr);

	always_comb begin
		dram_base_d = dram_base_q;
		dram_limit_d = dram_limit_q;
		regwin_base_d = regwin_base_q;
		lock_ctl_d = lock_ctl_q;
		prdata_d = prdata_q;
		pready_d = setup;
		pslverr_d = setup && (rsel == regsel_t'(5'h00));
		last_tgt_d = last_tgt_q;
		hole_cnt_d = hole_cnt_q;
		hole_done_d = sel_hole;
		if (commit && pwrite) begin
			case (rsel)
				REG_DRAM_BASE: dram_base_d = pwdata;
				REG_DRAM_LIMIT: dram_limit_d = pwdata;
				// low 21 bits read back zero: the window is always 2 MB aligned
				REG_REGWIN_BASE: regwin_base_d = {pwdata[31:`REGWIN_LSB], 21'h0};
				REG_LOCK_CTL: lock_ctl_d = {31'h0, pwdata[`HOLE_DIS_BIT]};
				default: begin
				end
			endcase
		end
		if (setup) begin
			case (rsel)
				REG_DRAM_BASE: prdata_d = dram_base_q;
				REG_DRAM_LIMIT: prdata_d = dram_limit_q;
				REG_REGWIN_BASE: prdata_d = regwin_base_q;
				REG_LOCK_CTL: prdata_d = lock_ctl_q;
				REG_STATUS: prdata_d = {hole_cnt_q, 12'h000, last_tgt_q};
				default: prdata_d = 32'h0000_0000;
			endcase
		end
		if (acc_valid) begin
			last_tgt_d = target_t'({sel_pci, sel_regwin, sel_dram, sel_hole});
		end
		if (sel_hole && (hole_cnt_q != 16'hffff)) begin
			hole_cnt_d = hole_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dram_base_q <= `RST_DRAM_BASE;
			dram_limit_q <= `RST_DRAM_LIMIT;
			regwin_base_q <= `RST_REGWIN_BASE;
			lock_ctl_q <= `RST_LOCK_CTL;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			last_tgt_q <= TGT_NONE;
			hole_cnt_q <= 16'h0000;
			hole_done_q <= 1'b0;
		end else begin
			dram_base_q <= dram_base_d;
			dram_limit_q <= dram_limit_d;
			regwin_base_q <= regwin_base_d;
			lock_ctl_q <= lock_ctl_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			last_tgt_q <= last_tgt_d;
			hole_cnt_q <= hole_cnt_d;
			hole_done_q <= hole_done_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign hole_done = hole_done_q;
	// zero load data is a constant; no external read is ever issued for it
	assign hole_rdata = 32'h0000_0000;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// decode checks look at the access port in the very cycle it is presented
	onehot_select_a: assert property (
		acc_valid |-> $onehot({sel_hole, sel_dram, sel_regwin, sel_pci}))
		else $error("target select not one-hot");

	idle_select_a: assert property (
		!acc_valid |-> !(sel_hole || sel_dram || sel_regwin || sel_pci))
		else $error("target selected with no access present");

	hole_range_a: assert property (
		sel_hole |-> (acc_addr <= `HOLE_TOP))
		else $error("hole selected outside 0..0xff");

	dram_bounds_a: assert property (
		sel_dram |-> (acc_addr >= dram_base_q)
			&& (acc_addr < dram_limit_q)
			&& ((acc_addr - dram_base_q) < 32'h0400_0000))
		else $error("dram selected outside window");

	// written from base, limit and the 64 MB cap directly, not from dram_top
	dram_claim_a: assert property (
		(acc_valid && (acc_addr >= dram_base_q) && (acc_addr < dram_limit_q)
			&& ((acc_addr - dram_base_q) < 32'h0400_0000)) |-> sel_dram)
		else $error("address inside dram window not sent to dram");

	regwin_span_a: assert property (
		sel_regwin |-> (acc_addr[31:`REGWIN_LSB] == regwin_base_q[31:`REGWIN_LSB]))
		else $error("register window selected outside 2 MB span");

	regwin_claim_a: assert property (
		(acc_valid && !sel_hole && !sel_dram
			&& (acc_addr[31:`REGWIN_LSB] == regwin_base_q[31:`REGWIN_LSB])) |-> sel_regwin)
		else $error("address inside register window not claimed");

	regwin_align_a: assert property (
		regwin_base_q[`REGWIN_LSB-1:0] == 21'h0)
		else $error("register window base not 2 MB aligned");

	pci_default_a: assert property (
		(acc_valid && !hit_dram && !hit_regwin && !acc_load) |-> sel_pci)
		else $error("unclaimed store not sent to pci");

	pci_load_a: assert property (
		(acc_valid && acc_load && (acc_addr > `HOLE_TOP) && !hit_dram && !hit_regwin)
			|-> sel_pci)
		else $error("unclaimed load not sent to pci");

	// both reset checks run at the first edge that samples rst low
	reset_state_a: assert property (
		$fell(rst) |-> (!lock_ctl_q[`HOLE_DIS_BIT] && (regwin_base_q == `RST_REGWIN_BASE)))
		else $error("hole or register window base wrong after reset");

	reset_idle_a: assert property (
		$fell(rst) |-> (hole_active && !pready && !pslverr && !hole_done
			&& (prdata == 32'h0000_0000)))
		else $error("outputs not idle after reset");

	hole_zero_a: assert property (
		sel_hole |=> (hole_done && (hole_rdata == 32'h0000_0000)))
		else $error("hole load not answered with zero");

	hole_done_src_a: assert property (
		hole_done |-> $past(sel_hole))
		else $error("hole answer with no hole load before it");

	// the count saturates instead of wrapping back to a small value
	hole_cnt_sat_a: assert property (
		(hole_cnt_q == 16'hffff) |=> (hole_cnt_q == 16'hffff))
		else $error("hole load count wrapped");

	store_pass_a: assert property (
		(acc_valid && !acc_load) |-> !sel_hole)
		else $error("store intercepted by hole");

	dram_overlap_a: assert property (
		(acc_valid && hit_dram) |-> sel_dram)
		else $error("dram address not routed to dram");

	hole_override_a: assert property (
		((dram_base_q <= `HOLE_TOP) && (dram_limit_q > dram_base_q)) |-> !sel_hole)
		else $error("hole active under an overlapping dram window");

	hole_off_a: assert property (
		lock_ctl_q[`HOLE_DIS_BIT] |-> !sel_hole)
		else $error("hole active while disabled");

	lock_bits_a: assert property (
		lock_ctl_q[31:1] == 31'h0)
		else $error("unused lock control bits set");

	// register port: one wait-free access phase, write lands at the access edge
	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("pready held for more than one cycle");

	err_pair_a: assert property (
		pslverr |-> pready)
		else $error("pslverr without pready");

	err_unmapped_a: assert property (
		(setup && (rsel == regsel_t'(5'h00))) |=> (pready && pslverr))
		else $error("unmapped register not refused");

	rdata_hold_a: assert property (
		!setup |=> $stable(prdata))
		else $error("read data moved outside a setup cycle");

	base_write_a: assert property (
		(commit && pwrite && (rsel == REG_DRAM_BASE)) |=> (dram_base_q == $past(pwdata)))
		else $error("dram base write did not land");

	limit_write_a: assert property (
		(commit && pwrite && (rsel == REG_DRAM_LIMIT)) |=> (dram_limit_q == $past(pwdata)))
		else $error("dram limit write did not land");

	regwin_write_a: assert property (
		(commit && pwrite && (rsel == REG_REGWIN_BASE))
			|=> (regwin_base_q[31:`REGWIN_LSB] == $past(pwdata[31:`REGWIN_LSB])))
		else $error("register window base write did not land");

	hole_load_c: cover property (sel_hole ##1 hole_done);
	dram_hit_c: cover property (sel_dram);
	regwin_hit_c: cover property (sel_regwin);
	hole_store_pci_c: cover property (acc_valid && !acc_load
		&& (acc_addr <= `HOLE_TOP) && sel_pci);
	hole_off_c: cover property (acc_valid && acc_load
		&& (acc_addr <= `HOLE_TOP) && lock_ctl_q[`HOLE_DIS_BIT] && sel_pci);
endmodule : address_aperture_decoder

// File: verilog/aperture_defs.svh
/*
 * offsets, field positions, reset values and limits of the aperture decoder.
 * assumes inclusion by bare name from the decoder module.
 */
`ifndef APERTURE_DEFS_SVH
`define APERTURE_DEFS_SVH

`define OFS_DRAM_BASE 12'h000
`define OFS_DRAM_LIMIT 12'h004
`define OFS_REGWIN_BASE 12'h008
`define OFS_LOCK_CTL 12'h00c
`define OFS_STATUS 12'h010

`define RST_DRAM_BASE 32'h0000_0000
`define RST_DRAM_LIMIT 32'h0000_0000
`define RST_REGWIN_BASE 32'hefe0_0000
`define RST_LOCK_CTL 32'h0000_0000

`define HOLE_DIS_BIT 0
`define HOLE_TOP 32'h0000_00ff
`define DRAM_MAX_SIZE 33'h0_0400_0000
`define REGWIN_LSB 21

`define STAT_TGT_LSB 0
`define STAT_CNT_LSB 16

`endif

// File: verilog/aperture_pkg.sv
/*
 * types shared by the aperture decoder.
 * assumes aperture_defs.svh is on the include path.
 */
package aperture_pkg;
	typedef enum logic [3:0] {
		TGT_NONE = 4'h0,
		TGT_HOLE = 4'h1,
		TGT_DRAM = 4'h2,
		TGT_REGWIN = 4'h4,
		TGT_PCI = 4'h8
	} target_t;

	typedef enum logic [4:0] {
		REG_DRAM_BASE = 5'h01,
		REG_DRAM_LIMIT = 5'h02,
		REG_REGWIN_BASE = 5'h04,
		REG_LOCK_CTL = 5'h08,
		REG_STATUS = 5'h10
	} regsel_t;
endpackage : aperture_pkg
